// file: bench/tcib_top_properties.sv
`timescale 1ns/1ns
module tcib_top_properties #(
    parameter int NFILT = 4,
    parameter int DEPTH_CELLS = 2
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic [NFILT-1:0] filt_hit_i,
    input wire logic extract_cell_present_i,
    input wire logic transmit_user_cell_queue_empty_i,
    input wire logic [31:0] tx_data_o,
    input wire logic tx_valid_o,
    input wire logic tx_soc_o,
    input wire logic tx_ready_i,
    input wire logic int_n_o
);
    logic [3:0] words_r;
    logic [3:0] words_nxt;
    wire logic hs = tx_valid_o && tx_ready_i;
    // Status read or enable write may legally lift the interrupt
    wire logic touch = (rd_i && addr_i == 8'h0B) || (wr_i && addr_i == 8'h0F);
    always_comb begin
        words_nxt = words_r;
        if (hs) begin
            words_nxt = tx_soc_o ? 4'h1 : words_r + 4'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            words_r <= 4'h0;
        end else begin
            words_r <= words_nxt;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence rd_at(logic [7:0] a);
        rd_i && addr_i == a;
    endsequence
    a_read_answer:
        assert property (rdata_o != 8'h00 |-> $past(rd_i))
        else $error("read data without a read");
    a_word_hold:
        assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
            && $stable(tx_data_o) && $stable(tx_soc_o))
        else $error("stalled word changed");
    a_cell_start:
        assert property (hs && tx_soc_o |-> words_r == 4'h0 || words_r == 4'hE)
        else $error("cell start inside a cell");
    a_cell_words:
        assert property (hs && !tx_soc_o |-> words_r inside {[4'h1:4'hD]})
        else $error("cell longer than fourteen words");
    a_int_cause:
        assert property ($fell(int_n_o) |-> words_r >= 4'h8)
        else $error("interrupt without a sent cell");
    a_int_holds:
        assert property (!int_n_o && !touch && !$past(touch) |=> !int_n_o)
        else $error("interrupt dropped by itself");
    a_ctrl_read:
        assert property (rd_at(8'h13) |=> rdata_o[3] ==
            $past(extract_cell_present_i) && rdata_o[7:5] == 3'h0)
        else $error("control read wrong");
    a_unmapped_zero:
        assert property (rd_at(8'h00) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule

// file: bench/tcib_top_tb.sv
`timescale 1ns/1ns
`include "tcib_regs.svh"
module tcib_top_tb;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] wdata_i = 8'h00;
    logic [3:0] filt_hit_i = 4'h0;
    logic extract_cell_present_i = 1'b0;
    logic transmit_user_cell_queue_empty_i = 1'b0;
    logic tx_ready_i = 1'b0;
    logic [7:0] rdata_o;
    logic [31:0] tx_data_o;
    logic tx_valid_o;
    logic tx_soc_o;
    logic int_n_o;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [32:0] got_q[$];
    tcib_top #(.NFILT(4), .DEPTH_CELLS(2)) dut (.clk_i(clk_i),
        .srst_i(srst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .filt_hit_i(filt_hit_i),
        .extract_cell_present_i(extract_cell_present_i),
        .transmit_user_cell_queue_empty_i(transmit_user_cell_queue_empty_i),
        .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_soc_o(tx_soc_o),
        .tx_ready_i(tx_ready_i), .int_n_o(int_n_o));
    always #10 clk_i = ~clk_i;
    // Receiver stalls every other cycle to exercise the buffer
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        tx_ready_i <= #1 ~tx_ready_i;
        if (tx_valid_o === 1'b1 && tx_ready_i) begin
            got_q.push_back({tx_soc_o, tx_data_o});
        end
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(logic [32:0] got, logic [32:0] exp, string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(posedge clk_i);
        #1;
        wr_i = 1'b0;
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] exp, logic [7:0] m);
        @(posedge clk_i);
        #1;
        addr_i = a;
        rd_i = 1'b1;
        @(posedge clk_i);
        #1;
        rd_i = 1'b0;
        chk({25'h0, rdata_o & m}, {25'h0, exp}, "register read");
    endtask
    function automatic logic [31:0] word(logic [7:0] c, logic [7:0] i);
        return {c, i, 8'hA5, ~i};
    endfunction
    // Poll the room bit; a bounded wait so a stuck bit cannot hang
    task automatic wait_room();
        for (int n = 0; n < 50; n++) begin
            @(posedge clk_i);
            #1;
            addr_i = `TCIB_MEMCTL_ADDR;
            rd_i = 1'b1;
            @(posedge clk_i);
            #1;
            rd_i = 1'b0;
            if (rdata_o[`TCIB_MC_ROOM_BIT] === 1'b1) begin
                return;
            end
        end
        mismatches++;
        $display("MISMATCH t=%0t no room for a cell", $time);
    endtask
    task automatic flush_buf();
        wr(`TCIB_MEMCTL_ADDR, 8'h10);
        wr(`TCIB_MEMCTL_ADDR, 8'h14);
    endtask
    task automatic load_cell(logic [7:0] c);
        logic [31:0] w;
        wait_room();
        wr(`TCIB_MEMCTL_ADDR, 8'h17);
        for (int i = 0; i < 14; i++) begin
            w = word(c, 8'(i));
            for (int k = 0; k < 4; k++) begin
                wr(`TCIB_DATA_B3_ADDR + 8'(k), w[31-8*k -: 8]);
            end
        end
    endtask
    task automatic test_reset();
        rdc(`TCIB_MEMCTL_ADDR, 8'h16, 8'hFE);
        rdc(`TCIB_INT_EN_ADDR, 8'h10, 8'hFF);
        rdc(8'h00, 8'h00, 8'hFF);
        for (int b = 0; b < 16; b++) begin
            rdc(8'h4C + 8'((b / 4) * 16 + b % 4), 8'h00, 8'hFF);
        end
        $display("reset test done");
    endtask
    // Extra hit after the top byte read must not show in the later bytes
    task automatic test_tally();
        for (int f = 0; f < 4; f++) begin
            repeat (f + 2) begin
                @(posedge clk_i);
                #1;
                filt_hit_i[f] = 1'b1;
                @(posedge clk_i);
                #1;
                filt_hit_i[f] = 1'b0;
            end
            rdc(8'h4C + 8'(16 * f), 8'h00, 8'hFF);
            filt_hit_i[f] = 1'b1;
            @(posedge clk_i);
            #1;
            filt_hit_i[f] = 1'b0;
            rdc(8'h4D + 8'(16 * f), 8'h00, 8'hFF);
            rdc(8'h4E + 8'(16 * f), 8'h00, 8'hFF);
            rdc(8'h4F + 8'(16 * f), 8'(f + 2), 8'hFF);
            for (int b = 0; b < 4; b++) begin
                rdc(8'h4C + 8'(16 * f + b), 8'h00, 8'hFF);
            end
        end
        $display("tally test done");
    endtask
    task automatic test_flush();
        flush_buf();
        load_cell(8'h09);
        flush_buf();
        transmit_user_cell_queue_empty_i = 1'b1;
        repeat (60) @(posedge clk_i);
        #1;
        chk(33'(got_q.size()), 33'h0, "flushed cell sent");
        transmit_user_cell_queue_empty_i = 1'b0;
        rdc(`TCIB_MEMCTL_ADDR, 8'h02, 8'h02);
        $display("flush test done");
    endtask
    task automatic test_send();
        load_cell(8'h01);
        load_cell(8'h02);
        extract_cell_present_i = 1'b1;
        rdc(`TCIB_MEMCTL_ADDR, 8'h08, 8'h0A);
        chk(33'(got_q.size()), 33'h0, "sent while busy");
        transmit_user_cell_queue_empty_i = 1'b1;
        for (int n = 0; n < 1000 && got_q.size() < 28; n++) begin
            @(posedge clk_i);
        end
        #1;
        chk(33'(got_q.size()), 33'h1C, "word count");
        for (int j = 0; j < 28 && j < got_q.size(); j++) begin
            chk(got_q[j], {j % 14 == 0, word(8'(1 + j / 14), 8'(j % 14))},
                "sent word");
        end
        chk({32'h0, int_n_o}, 33'h0, "interrupt low");
        rdc(`TCIB_INT_STAT_ADDR, 8'h10, 8'h10);
        repeat (3) @(posedge clk_i);
        #1;
        chk({32'h0, int_n_o}, 33'h1, "interrupt cleared");
        transmit_user_cell_queue_empty_i = 1'b0;
        extract_cell_present_i = 1'b0;
        rdc(`TCIB_MEMCTL_ADDR, 8'h02, 8'h0A);
        $display("send test done");
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        test_reset();
        test_tally();
        test_flush();
        test_send();
        give_verdict();
    end
endmodule
bind tcib_top tcib_top_properties #(.NFILT(NFILT), .DEPTH_CELLS(DEPTH_CELLS))
    u_props (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .filt_hit_i(filt_hit_i), .extract_cell_present_i(extract_cell_present_i),
    .transmit_user_cell_queue_empty_i(transmit_user_cell_queue_empty_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_soc_o(tx_soc_o),
    .tx_ready_i(tx_ready_i), .int_n_o(int_n_o));

// file: core/tcib_pkg.sv
package tcib_pkg;
    typedef enum logic [1:0] {
        TCIB_IDLE = 2'b00,
        TCIB_SEND = 2'b01
    } tcib_tx_state_t;
endpackage

// file: core/tcib_regs.svh
`ifndef TCIB_REGS_SVH
`define TCIB_REGS_SVH
// Register offsets within the processor's 8-bit map (low byte of address)
`define TCIB_MEMCTL_ADDR 8'h13
`define TCIB_DATA_B3_ADDR 8'h14
`define TCIB_DATA_B2_ADDR 8'h15
`define TCIB_DATA_B1_ADDR 8'h16
`define TCIB_DATA_B0_ADDR 8'h17
`define TCIB_INT_STAT_ADDR 8'h0B
`define TCIB_INT_EN_ADDR 8'h0F
`define TCIB_TALLY_BASE 8'h4C
`define TCIB_TALLY_STRIDE 8'h10
// Memory control and interrupt fields
`define TCIB_MC_SOC_BIT 0
`define TCIB_MC_ROOM_BIT 1
`define TCIB_MC_FLUSH_N_BIT 2
`define TCIB_MC_XPRES_BIT 3
`define TCIB_MC_XRST_N_BIT 4
`define TCIB_INT_INS_BIT 4
`define TCIB_INT_EN_RST 8'h10
// Cell geometry and tally limit
`define TCIB_WORDS_PER_CELL 4'hE
`define TCIB_TALLY_MAX 32'hFFFF_FFFF
`endif

// file: core/tcib_skid.sv
`timescale 1ns/1ns
// Two-entry buffer; a receiver stall loses no word
module tcib_skid #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    input wire logic in_first_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic out_first_o
);
    typedef struct packed {
        logic [1:0][W:0] mem;
        logic [1:0] cnt;
        logic rd;
        logic wr;
    } tcib_skid_st_t;
    tcib_skid_st_t st_r, st_nxt;
    logic push;
    logic pop;
    always_comb begin
        st_nxt = st_r;
        push = in_valid_i && (st_r.cnt != 2'd2);
        pop = (st_r.cnt != 2'd0) && out_ready_i;
        if (push) begin
            st_nxt.mem[st_r.wr] = {in_first_i, in_data_i};
            st_nxt.wr = ~st_r.wr;
        end
        if (pop) begin
            st_nxt.rd = ~st_r.rd;
        end
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign in_ready_o = (st_r.cnt != 2'd2);
    assign out_valid_o = (st_r.cnt != 2'd0);
    assign out_data_o = st_r.mem[st_r.rd][W-1:0];
    assign out_first_o = st_r.mem[st_r.rd][W];
endmodule

// file: core/tcib_top.sv
`timescale 1ns/1ns
`include "tcib_regs.svh"
module tcib_top
    import tcib_pkg::*;
#(
    parameter int NFILT = 4,
    parameter int DEPTH_CELLS = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Processor byte port
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // Filter events
    input wire logic [NFILT-1:0] filt_hit_i,
    // Extraction side status
    input wire logic extract_cell_present_i,
    // Transmit path
    input wire logic transmit_user_cell_queue_empty_i,
    output logic [31:0] tx_data_o,
    output logic tx_valid_o,
    output logic tx_soc_o,
    input wire logic tx_ready_i,
    output logic int_n_o
);
    localparam int WORDS = DEPTH_CELLS * 14;
    localparam int AW = $clog2(WORDS);
    typedef struct packed {
        logic [NFILT-1:0][31:0] tally;
        logic [NFILT-1:0][31:0] snap;
        logic [WORDS-1:0][32:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [2:0] cells;
        logic [3:0] wcnt;
        logic [3:0] rcnt;
        logic [23:0] hold;
        logic soc_pend;
        logic flush_n;
        logic xrst_n;
        logic sts_ins;
        logic [5:0] int_en;
        tcib_tx_state_t state;
        logic [7:0] rdata;
        logic int_n;
    } tcib_st_t;
    tcib_st_t st_r, st_nxt;
    logic in_ready;
    logic in_valid;
    logic [31:0] out_data;
    logic out_first;
    logic out_valid;
    function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
        return (p == AW'(WORDS - 1)) ? '0 : p + 1'b1;
    endfunction
    function automatic logic [2:0] tally_sel(input logic [7:0] a);
        logic [2:0] r;
        r = 3'b100;
        for (int f = 0; f < NFILT; f++) begin
            if (a[7:2] == 6'(({2'b0, `TCIB_TALLY_BASE} +
                f * `TCIB_TALLY_STRIDE) >> 2)) begin
                r = 3'(f);
            end
        end
        return r;
    endfunction
    logic [2:0] fsel;
    logic room;
    always_comb begin
        st_nxt = st_r;
        in_valid = 1'b0;
        fsel = tally_sel(addr_i);
        // Room means a whole cell fits; partial cells count as occupied
        room = (st_r.cells + (st_r.wcnt != 4'd0 ? 3'd1 : 3'd0))
            < 3'(DEPTH_CELLS);
        // Tallies count; a read clear of a counting cycle keeps the event
        for (int f = 0; f < NFILT; f++) begin
            if (rd_i && fsel == 3'(f) && addr_i[1:0] == 2'b11) begin
                st_nxt.tally[f] = {31'd0, filt_hit_i[f]};
            end else if (rd_i && fsel == 3'(f) && addr_i[1:0] == 2'b00) begin
                st_nxt.snap[f] = st_r.tally[f];
            end
            if (filt_hit_i[f] && st_r.tally[f] != `TCIB_TALLY_MAX &&
                !(rd_i && fsel == 3'(f) && addr_i[1:0] == 2'b11)) begin
                st_nxt.tally[f] = st_r.tally[f] + 32'd1;
            end
        end
        // Read data
        st_nxt.rdata = 8'h00;
        if (rd_i) begin
            if (fsel != 3'b100) begin
                unique case (addr_i[1:0])
                    2'b00: st_nxt.rdata = st_r.tally[fsel][31:24];
                    2'b01: st_nxt.rdata = st_r.snap[fsel][23:16];
                    2'b10: st_nxt.rdata = st_r.snap[fsel][15:8];
                    2'b11: st_nxt.rdata = st_r.snap[fsel][7:0];
                endcase
            end else if (addr_i == `TCIB_MEMCTL_ADDR) begin
                st_nxt.rdata = {3'b000, st_r.xrst_n, extract_cell_present_i,
                    st_r.flush_n, room, st_r.soc_pend};
            end else if (addr_i == `TCIB_INT_STAT_ADDR) begin
                st_nxt.rdata = 8'h00;
                st_nxt.rdata[`TCIB_INT_INS_BIT] = st_r.sts_ins;
                st_nxt.sts_ins = 1'b0;
            end else if (addr_i == `TCIB_INT_EN_ADDR) begin
                st_nxt.rdata = {2'b00, st_r.int_en};
            end
        end
        // Host writes
        if (wr_i) begin
            if (addr_i == `TCIB_MEMCTL_ADDR) begin
                st_nxt.flush_n = wdata_i[`TCIB_MC_FLUSH_N_BIT];
                st_nxt.xrst_n = wdata_i[`TCIB_MC_XRST_N_BIT];
                if (wdata_i[`TCIB_MC_SOC_BIT]) begin
                    st_nxt.soc_pend = 1'b1;
                    st_nxt.wcnt = 4'd0;
                end
            end else if (addr_i == `TCIB_INT_EN_ADDR) begin
                st_nxt.int_en = wdata_i[5:0];
            end else if (addr_i == `TCIB_DATA_B3_ADDR) begin
                st_nxt.hold[23:16] = wdata_i;
            end else if (addr_i == `TCIB_DATA_B2_ADDR) begin
                st_nxt.hold[15:8] = wdata_i;
            end else if (addr_i == `TCIB_DATA_B1_ADDR) begin
                st_nxt.hold[7:0] = wdata_i;
            end else if (addr_i == `TCIB_DATA_B0_ADDR && st_r.flush_n &&
                (st_r.wcnt != 4'd0 || room)) begin
                // Byte 0 completes the 32-bit word; words beyond room drop
                st_nxt.mem[st_r.wptr] = {st_r.soc_pend || st_r.wcnt == 4'd0,
                    st_r.hold, wdata_i};
                st_nxt.wptr = wrap(st_r.wptr);
                st_nxt.soc_pend = 1'b0;
                if (st_r.wcnt == `TCIB_WORDS_PER_CELL - 4'd1) begin
                    st_nxt.wcnt = 4'd0;
                    st_nxt.cells = st_nxt.cells + 3'd1;
                end else begin
                    st_nxt.wcnt = st_r.wcnt + 4'd1;
                end
            end
        end
        // Drain a whole cell into the outbound path when users are idle
        unique case (st_r.state)
            TCIB_IDLE: begin
                if (st_r.cells != 3'd0 && transmit_user_cell_queue_empty_i) begin
                    st_nxt.state = TCIB_SEND;
                    st_nxt.rcnt = 4'd0;
                end
            end
            TCIB_SEND: begin
                if (in_ready) begin
                    in_valid = 1'b1;
                    st_nxt.rptr = wrap(st_r.rptr);
                    st_nxt.rcnt = st_r.rcnt + 4'd1;
                    if (st_r.rcnt == `TCIB_WORDS_PER_CELL - 4'd1) begin
                        st_nxt.state = TCIB_IDLE;
                        st_nxt.cells = st_nxt.cells - 3'd1;
                        st_nxt.sts_ins = 1'b1;
                    end
                end
            end
        endcase
        // Flush while the active-low bit is low empties the cell store and returns to idle; words already in the skid buffer stay
        if (!st_r.flush_n) begin
            st_nxt.wptr = '0;
            st_nxt.rptr = '0;
            st_nxt.cells = 3'd0;
            st_nxt.wcnt = 4'd0;
            st_nxt.state = TCIB_IDLE;
        end
        st_nxt.int_n = !(st_nxt.sts_ins && st_r.int_en[`TCIB_INT_INS_BIT]);
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= '0;
            st_r.flush_n <= 1'b1;
            st_r.xrst_n <= 1'b1;
            st_r.int_en <= 6'(`TCIB_INT_EN_RST);
            st_r.int_n <= 1'b1;
            st_r.state <= TCIB_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end
    tcib_skid #(
        .W(32)
    ) u_skid (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(in_valid),
        .in_ready_o(in_ready),
        .in_data_i(st_r.mem[st_r.rptr][31:0]),
        .in_first_i(st_r.mem[st_r.rptr][32]),
        .out_valid_o(out_valid),
        .out_ready_i(tx_ready_i || !tx_valid_o),
        .out_data_o(out_data),
        .out_first_o(out_first)
    );
    // Output register stage so each port comes from a flip-flop
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o <= 32'h0000_0000;
            tx_soc_o <= 1'b0;
        end else if (tx_ready_i || !tx_valid_o) begin
            tx_valid_o <= out_valid;
            tx_data_o <= out_data;
            tx_soc_o <= out_first && out_valid;
        end
    end
    assign rdata_o = st_r.rdata;
    assign int_n_o = st_r.int_n;
endmodule
